// file: bench/test_wake_event_status_enable.sv
// Self-checking bench for the runtime wake registers and the wake request output
`timescale 1ns/1ps
module test_wake_event_status_enable;
  import wake_pkg::*;
  logic clk_sys;
  logic rst;
  rt_req_t rt_req;
  logic [7:0] rt_rdata;
  logic rt_rack;
  logic [23:0] src;
  wake_vec_t source_wake_enable;
  logic wake_request_out_n;
  int wake_count;
  int miscompares;
  int checked;

  // Source vector uses the status layout: byte 0 at offset 04, bit 0 has no source
  wake_event_status_enable dut (
    .clk_sys(clk_sys), .rst(rst), .rt_req(rt_req), .rt_rdata(rt_rdata), .rt_rack(rt_rack),
    .ring_indicator_first(src[2]), .ring_indicator_second(src[1]), .keyboard_wake(src[3]),
    .mouse_wake(src[4]), .specific_key_wake(src[5]), .tachometer_one_wake(src[6]),
    .tachometer_two_wake(src[7]), .gpio_pin_1(src[15:8]), .gpio_pin_2_low(src[18:16]),
    .grouped_smi_status(src[19]), .gpio_pin_2_high(src[23:20]),
    .source_wake_enable(source_wake_enable), .wake_request_out_n(wake_request_out_n)
  );

  wake_host_model host (
    .clk_sys(clk_sys), .rst(rst), .wake_request_out_n(wake_request_out_n),
    .wake_count(wake_count)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic results;
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bus tasks start and end 1 ns after an edge; an idle cycle keeps strobes apart
  task automatic wr(input logic [6:0] off, input logic [7:0] v);
    rt_req = '{1'b1, 1'b0, off, v};
    @(posedge clk_sys);
    #1 rt_req = '0;
    @(posedge clk_sys);
    #1;
  endtask

  // Acknowledge and data are registered, so both are looked at just after the taken edge
  task automatic rd(input logic [6:0] off, input logic [7:0] exp);
    rt_req = '{1'b0, 1'b1, off, 8'h00};
    @(posedge clk_sys);
    #1 rt_req = '0;
    chk({7'h00, rt_rack}, 8'h01);
    chk(rt_rdata, exp);
    @(posedge clk_sys);
    #1;
  endtask

  // Pin stays high past the filter and low long enough to be seen low again
  task automatic pulse(input int i);
    src[i] = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 src[i] = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic t_reset_map;
    for (int k = 0; k < 7; k++) rd(7'(k), 8'h00);
    wr(7'h01, 8'hFF);
    wr(7'h03, 8'hFF);
    rd(7'h01, 8'h00);
    rd(7'h03, 8'h00);
    wr(7'h07, 8'hFF);
    rd(7'h07, 8'h00);
    wr(7'h02, 8'hFF);
    rd(7'h02, 8'h01);
    wr(7'h02, 8'h00);
  endtask

  // Every source with all enables off: status latches, write-zero keeps, write-one clears
  task automatic t_sources;
    for (int i = 1; i < 24; i++) begin
      pulse(i);
      rd(7'(4 + i / 8), 8'(1 << (i % 8)));
      wr(7'(4 + i / 8), ~8'(1 << (i % 8)));
      rd(7'(4 + i / 8), 8'(1 << (i % 8)));
      wr(7'(4 + i / 8), 8'(1 << (i % 8)));
      rd(7'(4 + i / 8), 8'h00);
    end
    rd(7'h00, 8'h00);
  endtask

  task automatic t_flag;
    source_wake_enable[0][3] = 1'b1;
    pulse(3);
    rd(7'h00, 8'h01);
    chk({7'h00, wake_request_out_n}, 8'h01);
    wr(7'h00, 8'h01);
    rd(7'h00, 8'h01);
    wr(7'h02, 8'h01);
    chk({7'h00, wake_request_out_n}, 8'h00);
    wr(7'h00, 8'h00);
    rd(7'h00, 8'h01);
    wr(7'h04, 8'h08);
    wr(7'h00, 8'h01);
    rd(7'h00, 8'h00);
    chk({7'h00, wake_request_out_n}, 8'h01);
    source_wake_enable[0][3] = 1'b0;
    pulse(4);
    chk({7'h00, wake_request_out_n}, 8'h01);
    chk(8'(wake_count), 8'h01);
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    rd(7'h04, 8'h00);
    rd(7'h02, 8'h00);
  endtask

  initial begin
    rst = 1'b1;
    rt_req = '0;
    src = '0;
    source_wake_enable = '0;
    miscompares = 0;
    checked = 0;
    repeat (5) @(posedge clk_sys);
    #1 rst = 1'b0;
    t_reset_map;
    t_sources;
    t_flag;
    results;
  end

  // Whole run is about 600 cycles; some thirty times that means a hang
  initial begin
    #100000;
    miscompares++;
    results;
  end
endmodule

// file: bench/wake_host_model.sv
// Host power-management model that counts wake requests on the active-low line
`timescale 1ns/1ps
module wake_host_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wake_request_out_n,
  output int wake_count
);
  logic prev_n;

  // The line is a level, so only a fall starts a new request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_n <= 1'b1;
      wake_count <= 0;
    end else begin
      prev_n <= wake_request_out_n;
      if (prev_n && !wake_request_out_n) begin
        wake_count <= wake_count + 1;
      end
    end
  end
endmodule

// file: rtl/wake_event_status_enable.sv
// Runtime wake-event status, summary flag, master enable and wake request output
`timescale 1ns/1ps
`include "wake_regs.svh"

// How it works
// RQ1 - Summary flag sets whenever a wake would drive
// RQ2 - Registers clear only on standby power reset
// RQ3 - Writing one clears flag, releases wake output
// RQ4 - Writing zero keeps flag; upper bits reserved
// RQ5 - Offsets 01 and 03 read zero
// RQ6 - Master enable bit gates wake output
// RQ7 - Source events set status regardless of enables
// RQ8 - Status bits clear on write one only
// RQ9 - Status one maps rings, keys, mouse, tachometers
// RQ10 - Status two maps pins 10 to 17
// RQ11 - Status three maps pins 20-27 and SMI
// RQ12 - Drive needs source enable, status, master enable
// RQ13 - Host reaches registers at base plus offset
// RQ14 - Output released when nothing pending, flag cleared
module wake_event_status_enable
  import wake_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire rt_req_t rt_req,
  output logic [7:0] rt_rdata,
  output logic rt_rack,
  input wire logic ring_indicator_first,
  input wire logic ring_indicator_second,
  input wire logic keyboard_wake,
  input wire logic mouse_wake,
  input wire logic specific_key_wake,
  input wire logic tachometer_one_wake,
  input wire logic tachometer_two_wake,
  input wire logic [7:0] gpio_pin_1,
  input wire logic [2:0] gpio_pin_2_low,
  input wire logic [3:0] gpio_pin_2_high,
  input wire logic grouped_smi_status,
  input wire wake_vec_t source_wake_enable,
  output logic wake_request_out_n
);

  // Valid status bits; bit 0 of status one is reserved and never sets
  localparam wake_vec_t STS_VALID = {`WAKE_STS_THREE_VALID, `WAKE_STS_TWO_VALID,
                                     `WAKE_STS_ONE_VALID};

  wake_vec_t raw_pins;
  wake_vec_t pin_rise;
  wake_vec_t events;
  wake_vec_t wake_status;
  wake_vec_t next_wake_status;
  wake_vec_t status_clear;
  logic wake_summary_flag;
  logic next_wake_summary_flag;
  logic wake_master_enable_bit;
  logic next_wake_master_enable_bit;
  logic smi_prev;
  logic pending;
  logic next_pending;
  logic next_wake_request_out_n;
  logic [7:0] next_rt_rdata;
  logic next_rt_rack;
  logic wr_summary;
  logic wr_master;
  logic [1:0] sts_index;
  logic wr_status;

  // Pins laid out exactly as the status bytes read back
  always_comb begin
    raw_pins[0] = {tachometer_two_wake, tachometer_one_wake, specific_key_wake, mouse_wake,
                   keyboard_wake, ring_indicator_first, ring_indicator_second, 1'b0}; // [RQ9]
    raw_pins[1] = gpio_pin_1; // [RQ10]
    raw_pins[2] = {gpio_pin_2_high, 1'b0, gpio_pin_2_low}; // [RQ11]
  end

  // Pins arrive from outside the clock domain, so they are filtered and edge detected
  wake_input_sync #(
    .WIDTH(24)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(raw_pins),
    .rise_pulse(pin_rise)
  );

  // The grouped SMI status is on-chip logic on this clock and needs no synchroniser
  always_comb begin
    events = pin_rise & STS_VALID;
    events[`WAKE_SMI_INDEX / 8][`WAKE_SMI_INDEX % 8] = grouped_smi_status && !smi_prev; // [RQ11]
  end

  // Write decode; the host side has already matched the block base address
  always_comb begin
    wr_summary = rt_req.wr && (rt_req.offset == `WAKE_OFF_SUMMARY);
    wr_master = rt_req.wr && (rt_req.offset == `WAKE_OFF_MASTER);
    wr_status = rt_req.wr && (rt_req.offset >= `WAKE_OFF_STS_ONE) &&
                (rt_req.offset <= `WAKE_OFF_STS_THREE);
    sts_index = 2'(rt_req.offset - `WAKE_OFF_STS_ONE);
    status_clear = '0;
    if (wr_status) begin
      status_clear[sts_index] = rt_req.wdata; // [RQ8]
    end
  end

  // Status: a new event wins over a clear landing in the same cycle
  always_comb begin
    next_wake_status = (wake_status & ~status_clear) | events; // [RQ7] [RQ8]
    next_pending = |(next_wake_status & source_wake_enable); // [RQ12]
    next_wake_master_enable_bit = wake_master_enable_bit;
    if (wr_master) begin
      next_wake_master_enable_bit = rt_req.wdata[`WAKE_MASTER_EN_BIT]; // [RQ6]
    end
    // Flag follows pending work regardless of the master enable; set wins over clear
    next_wake_summary_flag = wake_summary_flag;
    if (wr_summary && rt_req.wdata[`WAKE_SUMMARY_FLAG_BIT]) begin
      next_wake_summary_flag = 1'b0; // [RQ3] [RQ4]
    end
    if (next_pending) begin
      next_wake_summary_flag = 1'b1; // [RQ1]
    end
    // Output is low only while the flag stands and the master enable is on
    next_wake_request_out_n = !(next_wake_summary_flag && next_wake_master_enable_bit); // [RQ6] [RQ14]
  end

  // Read mux; reserved offsets and bits, and anything past the map, read as zero
  always_comb begin
    next_rt_rdata = rt_rdata;
    next_rt_rack = rt_req.rd;
    if (rt_req.rd) begin
      unique case (rt_req.offset)
        `WAKE_OFF_SUMMARY: next_rt_rdata = {7'h00, wake_summary_flag}; // [RQ4]
        `WAKE_OFF_MASTER: next_rt_rdata = {7'h00, wake_master_enable_bit}; // [RQ4]
        `WAKE_OFF_STS_ONE: next_rt_rdata = wake_status[0];
        `WAKE_OFF_STS_TWO: next_rt_rdata = wake_status[1];
        `WAKE_OFF_STS_THREE: next_rt_rdata = wake_status[2];
        default: next_rt_rdata = 8'h00; // [RQ5]
      endcase
    end
  end

  // rst is the standby power reset; main power and soft resets never reach here
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_status <= {`WAKE_RESET_VALUE, `WAKE_RESET_VALUE, `WAKE_RESET_VALUE}; // [RQ2]
      wake_summary_flag <= 1'b0; // [RQ2]
      wake_master_enable_bit <= 1'b0; // [RQ2]
      pending <= 1'b0;
      smi_prev <= 1'b0;
      wake_request_out_n <= 1'b1;
      rt_rdata <= 8'h00;
      rt_rack <= 1'b0;
    end else begin
      wake_status <= next_wake_status;
      wake_summary_flag <= next_wake_summary_flag;
      wake_master_enable_bit <= next_wake_master_enable_bit;
      pending <= next_pending;
      smi_prev <= grouped_smi_status;
      wake_request_out_n <= next_wake_request_out_n;
      rt_rdata <= next_rt_rdata;
      rt_rack <= next_rt_rack;
    end
  end

  // Checks on the design's own outputs and state
  sequence seq_flag_clear_write;
    rt_req.wr && rt_req.offset == `WAKE_OFF_SUMMARY && rt_req.wdata[0];
  endsequence

  sequence seq_nothing_pending;
    !(|(next_wake_status & source_wake_enable));
  endsequence

  sequence seq_reserved_read;
    rt_req.rd && (rt_req.offset == `WAKE_OFF_GAP_ONE || rt_req.offset == `WAKE_OFF_GAP_THREE);
  endsequence

  a_flag_follows_pending: assert property (@(posedge clk_sys) disable iff (rst) // [RQ1]
    pending |-> wake_summary_flag)
    else $error("summary flag low while an enabled source is pending");

  a_reset_clears_all: assert property (@(posedge clk_sys) // [RQ2]
    rst |=> (wake_status == '0) && !wake_summary_flag && !wake_master_enable_bit)
    else $error("standby reset did not clear the wake registers");

  a_flag_w1c_release: assert property (@(posedge clk_sys) disable iff (rst) // [RQ3]
    (seq_flag_clear_write and seq_nothing_pending) |=> !wake_summary_flag && wake_request_out_n)
    else $error("summary flag or wake output survived a write of one");

  a_flag_zero_write: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
    (rt_req.wr && rt_req.offset == `WAKE_OFF_SUMMARY && !rt_req.wdata[0] && wake_summary_flag)
    |=> wake_summary_flag)
    else $error("writing zero disturbed the summary flag");

  a_reserved_read_zero: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
    seq_reserved_read |=> rt_rack && rt_rdata == 8'h00)
    else $error("reserved offset read back nonzero");

  a_master_blocks_out: assert property (@(posedge clk_sys) disable iff (rst) // [RQ6]
    !wake_master_enable_bit |-> wake_request_out_n && (wake_request_out_n ==
      !(wake_summary_flag && wake_master_enable_bit)))
    else $error("wake output driven while master enable is off");

  a_event_sets_status: assert property (@(posedge clk_sys) disable iff (rst) // [RQ7]
    (|events) |=> ((wake_status & $past(events)) == $past(events)))
    else $error("wake event did not set its status bit");

  a_status_w1c: assert property (@(posedge clk_sys) disable iff (rst) // [RQ8]
    (rt_req.wr && rt_req.offset == `WAKE_OFF_STS_TWO && events[1] == 8'h00)
    |=> (wake_status[1] & $past(rt_req.wdata)) == 8'h00)
    else $error("status bit written with one did not clear");

  a_drive_needs_all: assert property (@(posedge clk_sys) disable iff (rst) // [RQ12]
    !wake_request_out_n |-> wake_master_enable_bit && wake_summary_flag)
    else $error("wake output low without flag and master enable");

  a_release_when_idle: assert property (@(posedge clk_sys) disable iff (rst) // [RQ14]
    (!pending && !wake_summary_flag) |-> wake_request_out_n)
    else $error("wake output held with nothing pending and flag clear");

  // Named steps: a read strobe to offset 00 or 02, and a rise of the grouped SMI status
  sequence seq_summary_read;
    rt_req.rd && rt_req.offset == `WAKE_OFF_SUMMARY;
  endsequence

  sequence seq_master_read;
    rt_req.rd && rt_req.offset == `WAKE_OFF_MASTER;
  endsequence

  sequence seq_smi_rise;
    grouped_smi_status && !smi_prev;
  endsequence

  // The enable only moves on a write to its own offset
  a_master_write_lands: assert property (@(posedge clk_sys) disable iff (rst) // [RQ6]
    wr_master |=> wake_master_enable_bit == $past(rt_req.wdata[`WAKE_MASTER_EN_BIT]))
    else $error("master enable write did not land");

  a_master_holds_idle: assert property (@(posedge clk_sys) disable iff (rst) // [RQ6]
    !wr_master |=> $stable(wake_master_enable_bit))
    else $error("master enable changed without a write");

  // Bit 0 of status one has no source behind it
  a_reserved_status_bit: assert property (@(posedge clk_sys) disable iff (rst) // [RQ9]
    !wake_status[0][0])
    else $error("reserved status bit set");

  // Every read is answered exactly one cycle later, and only then
  a_read_ack_pulse: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
    rt_req.rd |=> rt_rack)
    else $error("read strobe not acknowledged");

  a_no_stray_ack: assert property (@(posedge clk_sys) disable iff (rst) // [RQ5]
    !rt_req.rd |=> !rt_rack)
    else $error("acknowledge without a read strobe");

  // Reserved upper bits of the summary and enable registers read as zero
  a_summary_read_back: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
    seq_summary_read |=> rt_rdata == {7'h00, $past(wake_summary_flag)})
    else $error("summary register read back wrong");

  a_master_read_back: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
    seq_master_read |=> rt_rdata == {7'h00, $past(wake_master_enable_bit)})
    else $error("master enable register read back wrong");

  // A status bit only rises where an event was latched the cycle before
  a_status_needs_event: assert property (@(posedge clk_sys) disable iff (rst) // [RQ7]
    1'b1 |=> (wake_status & ~$past(wake_status) & ~$past(events)) == '0)
    else $error("status bit set without a wake event");

  // The grouped SMI rise lands in bit 3 of status three on the next edge
  a_smi_sets_status: assert property (@(posedge clk_sys) disable iff (rst) // [RQ11]
    seq_smi_rise |=> wake_status[2][3])
    else $error("grouped SMI rise did not set its status bit");

  // Without a write to offset 00 nothing may clear the flag
  a_flag_holds: assert property (@(posedge clk_sys) disable iff (rst) // [RQ4]
    (wake_summary_flag && !wr_summary) |=> wake_summary_flag)
    else $error("summary flag cleared without a write");

  // Flag and enable together always pull the line low
  a_drive_when_armed: assert property (@(posedge clk_sys) disable iff (rst) // [RQ12]
    (wake_master_enable_bit && wake_summary_flag) |-> !wake_request_out_n)
    else $error("wake output idle while flag and master enable stand");

  // A write of zeros to a status byte clears nothing
  a_status_zero_write: assert property (@(posedge clk_sys) disable iff (rst) // [RQ8]
    (wr_status && rt_req.wdata == 8'h00) |=> ($past(wake_status) & ~wake_status) == '0)
    else $error("status bit cleared by a write of zero");

  // Writes outside the status offsets never touch status
  a_status_foreign_write: assert property (@(posedge clk_sys) disable iff (rst) // [RQ8]
    !wr_status |=> ($past(wake_status) & ~wake_status) == '0)
    else $error("status bit cleared without a status write");

  // A flag with no pending source and no master enable leaves the line released
  a_line_idle_no_master: assert property (@(posedge clk_sys) disable iff (rst) // [RQ14]
    (!wake_master_enable_bit && !pending) |-> wake_request_out_n)
    else $error("wake output low while disabled and idle");

  // Pending follows the enabled status, whatever the master enable says
  a_pending_tracks: assert property (@(posedge clk_sys) disable iff (rst) // [RQ1]
    pending == |(wake_status & source_wake_enable) || $past(rst))
    else $error("pending does not match enabled status");

endmodule

// file: rtl/wake_input_sync.sv
// Pin synchroniser with agreement filter and rising-edge pulse, one per bit
`timescale 1ns/1ps
module wake_input_sync #(
  parameter int WIDTH = 24
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] rise_pulse
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1, s2, s3, level, rise;
      logic next_level, next_rise;
      // A change is accepted only once stages two and three agree
      always_comb begin
        next_level = (s2 == s3) ? s3 : level;
        next_rise = (s2 == s3) && s3 && !level;
      end
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          level <= 1'b0;
          rise <= 1'b0;
        end else begin
          s1 <= pin_in[i];
          s2 <= s1;
          s3 <= s2;
          level <= next_level;
          rise <= next_rise;
        end
      end
      assign rise_pulse[i] = rise;
    end
  endgenerate
endmodule

// file: rtl/wake_pkg.sv
// Types shared by the runtime wake-event logic
package wake_pkg;
  // Three wake status bytes, index 0 at offset 04
  typedef logic [2:0][7:0] wake_vec_t;
  // One runtime register access, offset already relative to the block base
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] offset;
    logic [7:0] wdata;
  } rt_req_t;
endpackage

// file: rtl/wake_regs.svh
// Register offsets, field positions and reset values of the runtime wake registers
`ifndef WAKE_REGS_SVH
`define WAKE_REGS_SVH

`define WAKE_OFFSET_W 7
`define WAKE_OFF_SUMMARY 7'h00
`define WAKE_OFF_GAP_ONE 7'h01
`define WAKE_OFF_MASTER 7'h02
`define WAKE_OFF_GAP_THREE 7'h03
`define WAKE_OFF_STS_ONE 7'h04
`define WAKE_OFF_STS_TWO 7'h05
`define WAKE_OFF_STS_THREE 7'h06
`define WAKE_STS_COUNT 3
`define WAKE_SUMMARY_FLAG_BIT 0
`define WAKE_MASTER_EN_BIT 0
`define WAKE_RESET_VALUE 8'h00
`define WAKE_STS_ONE_VALID 8'hFE
`define WAKE_STS_TWO_VALID 8'hFF
`define WAKE_STS_THREE_VALID 8'hFF
`define WAKE_SMI_INDEX 19

`endif
